/* File: jmirq_regs.svh */
// register offsets, field positions, reset values and timing of the joystick control block
// Summary of operation
// - low-power mode: oscillator-timed measurements, eight periods
// - idle mode: measure after Y read acknowledge
// - time base selects 20 to 320 ms
// - interrupt-off bit releases the pin
// - idle mode: interrupt when triggered measurement completes
// - low-power mode: interrupt after each timed measurement
// - interrupt released after Y read acknowledge
// - dead-zone mode: interrupt only outside zone
// - dead-zone mode: reassert next measurement if outside
// - soft reset reloads all registers, self-clears
// - ready flag low during conversion, high after
// - pointer on 0Fh-11h freezes control, X, Y
// - control register resets to F0h
// - coordinates signed 8-bit, positive X is left
// - four signed threshold registers with resets
`ifndef JMIRQ_REGS_SVH
`define JMIRQ_REGS_SVH

`define JM_ADDR_CTRL 8'h0F
`define JM_ADDR_X 8'h10
`define JM_ADDR_Y 8'h11
`define JM_ADDR_LEFT 8'h12
`define JM_ADDR_RIGHT 8'h13
`define JM_ADDR_TOP 8'h14
`define JM_ADDR_BOTTOM 8'h15

`define JM_BIT_IDLE 7
`define JM_BIT_TB_HI 6
`define JM_BIT_TB_LO 4
`define JM_BIT_INT_OFF 3
`define JM_BIT_INT_ZONE 2
`define JM_BIT_SOFT_RST 1
`define JM_BIT_READY 0

`define JM_RST_CTRL 8'hF0
`define JM_RST_X 8'h00
`define JM_RST_Y 8'h00
`define JM_RST_LEFT 8'h05
`define JM_RST_RIGHT 8'hFB
`define JM_RST_TOP 8'h05
`define JM_RST_BOTTOM 8'hFB

`define JM_CLK_MHZ 125
`define JM_US_PER_MS 1000
`define JM_SRST_CYCLES 4'h4

`define JM_TB_MS_0 20
`define JM_TB_MS_1 40
`define JM_TB_MS_2 80
`define JM_TB_MS_3 100
`define JM_TB_MS_4 140
`define JM_TB_MS_5 200
`define JM_TB_MS_6 260
`define JM_TB_MS_7 320

`endif

/* File: jmirq_pkg.sv */
// types shared by the joystick control block
package jmirq_pkg;

   typedef enum logic [1:0] {
      JMIRQ_REQ_PTR,
      JMIRQ_REQ_READ,
      JMIRQ_REQ_WRITE,
      JMIRQ_REQ_YACK
   } jmirq_kind_t;

   typedef struct packed {
      jmirq_kind_t kind;
      logic [7:0] addr;
      logic [7:0] data;
   } jmirq_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } jmirq_rsp_t;

   typedef struct packed {
      logic signed [7:0] x;
      logic signed [7:0] y;
   } jmirq_coord_t;

   typedef enum logic [1:0] {
      JMIRQ_ST_READY,
      JMIRQ_ST_CONVERT,
      JMIRQ_ST_SRST
   } jmirq_state_t;

endpackage : jmirq_pkg

/* File: jmirq_handshake.sv */
// request/answer handshake carrying register requests from the link clock to the system clock
`timescale 1ns/1ps
module jmirq_handshake
(
   input wire logic linkClk,
   input wire logic linkRst,
   input wire logic linkValid,
   output logic linkReady,
   input jmirq_pkg::jmirq_req_t linkReq,
   output logic linkRspValid,
   output jmirq_pkg::jmirq_rsp_t linkRsp,
   input wire logic clk,
   input wire logic sys_rst,
   output logic sysValid,
   output jmirq_pkg::jmirq_req_t sysReq,
   input wire logic sysDone,
   input jmirq_pkg::jmirq_rsp_t sysRsp
);

   logic reqTgl;
   logic busy;
   jmirq_pkg::jmirq_req_t reqHold;
   logic ackMeta;
   logic ackSync;
   logic ackSeen;
   logic reqMeta;
   logic reqSync;
   logic reqSeen;
   logic ackTgl;
   jmirq_pkg::jmirq_rsp_t rspHold;

   assign linkReady = !busy;

   // link side: hold the request stable until the answer toggles back
   always_ff @(posedge linkClk)
   begin
      if (linkRst)
      begin
         reqTgl <= 1'b0;
         busy <= 1'b0;
         reqHold <= '0;
      end
      else if (linkValid && !busy)
      begin
         reqTgl <= !reqTgl;
         busy <= 1'b1;
         reqHold <= linkReq;
      end
      else if (busy && (ackSync != ackSeen))
      begin
         busy <= 1'b0;
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (linkRst)
      begin
         ackMeta <= 1'b0;
         ackSync <= 1'b0;
         ackSeen <= 1'b0;
         linkRspValid <= 1'b0;
         linkRsp <= '0;
      end
      else
      begin
         ackMeta <= ackTgl;
         ackSync <= ackMeta;
         ackSeen <= ackSync;
         linkRspValid <= busy && (ackSync != ackSeen);
         if (busy && (ackSync != ackSeen))
         begin
            linkRsp <= rspHold;
         end
      end
   end

   // system side: the held request is stable once its toggle is seen
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         reqMeta <= 1'b0;
         reqSync <= 1'b0;
         reqSeen <= 1'b0;
      end
      else
      begin
         reqMeta <= reqTgl;
         reqSync <= reqMeta;
         if (sysDone)
         begin
            reqSeen <= reqSync;
         end
      end
   end

   assign sysValid = (reqSync != reqSeen);
   assign sysReq = reqHold;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ackTgl <= 1'b0;
         rspHold <= '0;
      end
      else if (sysDone && sysValid)
      begin
         ackTgl <= !ackTgl;
         rspHold <= sysRsp;
      end
   end

endmodule : jmirq_handshake

/* File: jmirq_lp_timer.sv */
// low-power wake timer: one tick per selected time base period
`timescale 1ns/1ps
`include "jmirq_regs.svh"
module jmirq_lp_timer
#(
   parameter int unsigned MS_CYCLES = `JM_CLK_MHZ * `JM_US_PER_MS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [2:0] timeBase,
   output logic tick
);

   logic [31:0] msCount;
   logic [8:0] msLeft;
   logic [8:0] periodMs;

   // period of the wake-up in milliseconds
   always_comb
   begin
      case (timeBase)
         3'h0: periodMs = 9'(`JM_TB_MS_0);
         3'h1: periodMs = 9'(`JM_TB_MS_1);
         3'h2: periodMs = 9'(`JM_TB_MS_2);
         3'h3: periodMs = 9'(`JM_TB_MS_3);
         3'h4: periodMs = 9'(`JM_TB_MS_4);
         3'h5: periodMs = 9'(`JM_TB_MS_5);
         3'h6: periodMs = 9'(`JM_TB_MS_6);
         default: periodMs = 9'(`JM_TB_MS_7);
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !run)
      begin
         msCount <= 32'h0;
         msLeft <= periodMs;
         tick <= 1'b0;
      end
      else if (msCount == MS_CYCLES - 1)
      begin
         msCount <= 32'h0;
         tick <= (msLeft == 9'h1);
         msLeft <= (msLeft == 9'h1) ? periodMs : msLeft - 9'h1;
      end
      else
      begin
         msCount <= msCount + 32'h1;
         tick <= 1'b0;
      end
   end

endmodule : jmirq_lp_timer

/* File: jmirq_control.sv */
// control, status, dead-zone interrupt and register file of the joystick sensor
`timescale 1ns/1ps
`include "jmirq_regs.svh"
module jmirq_control
#(
   parameter int unsigned MS_CYCLES = `JM_CLK_MHZ * `JM_US_PER_MS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic linkClk,
   input wire logic linkRst,
   input wire logic linkValid,
   output logic linkReady,
   input jmirq_pkg::jmirq_req_t linkReq,
   output logic linkRspValid,
   output jmirq_pkg::jmirq_rsp_t linkRsp,
   output logic measStart,
   input wire logic measDone,
   input jmirq_pkg::jmirq_coord_t measCoord,
   output logic irqPinNOut,
   output logic irqPinNOe
);

   jmirq_pkg::jmirq_state_t state;
   jmirq_pkg::jmirq_state_t next_state;
   logic sysValid;
   jmirq_pkg::jmirq_req_t sysReq;
   logic sysDone;
   jmirq_pkg::jmirq_rsp_t sysRsp;
   logic [7:0] pointer;
   logic idleMode;
   logic [2:0] timeBase;
   logic intOff;
   logic intZone;
   logic sampleReady;
   jmirq_pkg::jmirq_coord_t coord;
   logic signed [7:0] leftThr;
   logic signed [7:0] rightThr;
   logic signed [7:0] topThr;
   logic signed [7:0] bottomThr;
   logic [7:0] frozenCtrl;
   jmirq_pkg::jmirq_coord_t frozenCoord;
   logic [7:0] liveCtrl;
   logic frozen;
   logic irqPending;
   logic outsideZone;
   logic lpTick;
   logic yAck;
   logic regWrite;
   logic softRst;
   logic [3:0] srstCount;
   logic trigger;
   logic irqSet;

   jmirq_handshake u_handshake
   (
      .linkClk(linkClk),
      .linkRst(linkRst),
      .linkValid(linkValid),
      .linkReady(linkReady),
      .linkReq(linkReq),
      .linkRspValid(linkRspValid),
      .linkRsp(linkRsp),
      .clk(clk),
      .sys_rst(sys_rst),
      .sysValid(sysValid),
      .sysReq(sysReq),
      .sysDone(sysDone),
      .sysRsp(sysRsp)
   );

   jmirq_lp_timer #(.MS_CYCLES(MS_CYCLES)) u_lp_timer
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(!idleMode && state != jmirq_pkg::JMIRQ_ST_SRST),
      .timeBase(timeBase),
      .tick(lpTick)
   );

   // every request is answered in the cycle it is seen
   assign sysDone = sysValid;
   assign yAck = sysValid && (sysReq.kind == jmirq_pkg::JMIRQ_REQ_YACK);
   assign regWrite = sysValid && (sysReq.kind == jmirq_pkg::JMIRQ_REQ_WRITE);
   assign softRst = (state == jmirq_pkg::JMIRQ_ST_SRST);

   // address pointer follows the address of every request except a Y read acknowledge
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pointer <= 8'h00;
      end
      else if (sysValid && (sysReq.kind != jmirq_pkg::JMIRQ_REQ_YACK))
      begin
         pointer <= sysReq.addr;
      end
   end

   // measurement sequencer
   assign trigger = idleMode ? yAck : lpTick;

   always_comb
   begin
      next_state = state;
      case (state)
         jmirq_pkg::JMIRQ_ST_READY:
         begin
            if (trigger)
            begin
               next_state = jmirq_pkg::JMIRQ_ST_CONVERT;
            end
         end
         jmirq_pkg::JMIRQ_ST_CONVERT:
         begin
            if (measDone)
            begin
               next_state = jmirq_pkg::JMIRQ_ST_READY;
            end
         end
         default:
         begin
            if (srstCount == 4'h0)
            begin
               next_state = jmirq_pkg::JMIRQ_ST_READY;
            end
         end
      endcase
      if (regWrite && sysReq.addr == `JM_ADDR_CTRL && sysReq.data[`JM_BIT_SOFT_RST])
      begin
         next_state = jmirq_pkg::JMIRQ_ST_SRST;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= jmirq_pkg::JMIRQ_ST_READY;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         srstCount <= 4'h0;
      end
      else if (next_state == jmirq_pkg::JMIRQ_ST_SRST && !softRst)
      begin
         srstCount <= `JM_SRST_CYCLES;
      end
      else if (softRst && srstCount != 4'h0)
      begin
         srstCount <= srstCount - 4'h1;
      end
   end

   assign measStart = (state == jmirq_pkg::JMIRQ_ST_READY) && trigger;

   // control register fields
   always_ff @(posedge clk)
   begin
      if (sys_rst || softRst)
      begin
         idleMode <= 1'(`JM_RST_CTRL >> `JM_BIT_IDLE);
         timeBase <= 3'(`JM_RST_CTRL >> `JM_BIT_TB_LO);
         intOff <= 1'(`JM_RST_CTRL >> `JM_BIT_INT_OFF);
         intZone <= 1'(`JM_RST_CTRL >> `JM_BIT_INT_ZONE);
      end
      else if (regWrite && sysReq.addr == `JM_ADDR_CTRL)
      begin
         idleMode <= sysReq.data[`JM_BIT_IDLE];
         timeBase <= sysReq.data[`JM_BIT_TB_HI:`JM_BIT_TB_LO];
         intOff <= sysReq.data[`JM_BIT_INT_OFF];
         intZone <= sysReq.data[`JM_BIT_INT_ZONE];
      end
   end

   // dead-zone thresholds
   always_ff @(posedge clk)
   begin
      if (sys_rst || softRst)
      begin
         leftThr <= `JM_RST_LEFT;
         rightThr <= `JM_RST_RIGHT;
         topThr <= `JM_RST_TOP;
         bottomThr <= `JM_RST_BOTTOM;
      end
      else if (regWrite)
      begin
         if (sysReq.addr == `JM_ADDR_LEFT)
         begin
            leftThr <= sysReq.data;
         end
         else if (sysReq.addr == `JM_ADDR_RIGHT)
         begin
            rightThr <= sysReq.data;
         end
         else if (sysReq.addr == `JM_ADDR_TOP)
         begin
            topThr <= sysReq.data;
         end
         else if (sysReq.addr == `JM_ADDR_BOTTOM)
         begin
            bottomThr <= sysReq.data;
         end
      end
   end

   // live coordinates and ready flag
   always_ff @(posedge clk)
   begin
      if (sys_rst || softRst)
      begin
         coord <= {`JM_RST_X, `JM_RST_Y};
         sampleReady <= 1'b0;
      end
      else if (state == jmirq_pkg::JMIRQ_ST_CONVERT && measDone)
      begin
         coord <= measCoord;
         sampleReady <= 1'b1;
      end
      else if (measStart)
      begin
         sampleReady <= 1'b0;
      end
   end

   assign liveCtrl = {idleMode, timeBase, intOff, intZone, softRst, sampleReady};

   // snapshot held while the pointer sits on control, X or Y
   assign frozen = (pointer == `JM_ADDR_CTRL) || (pointer == `JM_ADDR_X)
      || (pointer == `JM_ADDR_Y);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         frozenCtrl <= `JM_RST_CTRL;
         frozenCoord <= {`JM_RST_X, `JM_RST_Y};
      end
      else if (!frozen)
      begin
         frozenCtrl <= liveCtrl;
         frozenCoord <= coord;
      end
   end

   // register answers; unmapped addresses read zero and are not acknowledged
   always_comb
   begin
      sysRsp = '0;
      if (sysReq.addr == `JM_ADDR_CTRL)
      begin
         sysRsp.valid = 1'b1;
         sysRsp.data = frozen ? frozenCtrl : liveCtrl;
      end
      else if (sysReq.addr == `JM_ADDR_X)
      begin
         sysRsp.valid = sysReq.kind != jmirq_pkg::JMIRQ_REQ_WRITE;
         sysRsp.data = frozen ? frozenCoord.x : coord.x;
      end
      else if (sysReq.addr == `JM_ADDR_Y)
      begin
         sysRsp.valid = sysReq.kind != jmirq_pkg::JMIRQ_REQ_WRITE;
         sysRsp.data = frozen ? frozenCoord.y : coord.y;
      end
      else if (sysReq.addr == `JM_ADDR_LEFT)
      begin
         sysRsp.valid = 1'b1;
         sysRsp.data = leftThr;
      end
      else if (sysReq.addr == `JM_ADDR_RIGHT)
      begin
         sysRsp.valid = 1'b1;
         sysRsp.data = rightThr;
      end
      else if (sysReq.addr == `JM_ADDR_TOP)
      begin
         sysRsp.valid = 1'b1;
         sysRsp.data = topThr;
      end
      else if (sysReq.addr == `JM_ADDR_BOTTOM)
      begin
         sysRsp.valid = 1'b1;
         sysRsp.data = bottomThr;
      end
   end

   // knob outside the dead zone, signed compare on the new sample
   assign outsideZone = (measCoord.x > leftThr) || (measCoord.x < rightThr)
      || (measCoord.y > topThr) || (measCoord.y < bottomThr);

   assign irqSet = (state == jmirq_pkg::JMIRQ_ST_CONVERT) && measDone
      && (!intZone || outsideZone);

   // pending interrupt: a new measurement wins over a simultaneous clear
   always_ff @(posedge clk)
   begin
      if (sys_rst || softRst)
      begin
         irqPending <= 1'b0;
      end
      else if (irqSet)
      begin
         irqPending <= 1'b1;
      end
      else if (yAck)
      begin
         irqPending <= 1'b0;
      end
   end

   // open-drain pin: drives low only while pending and enabled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irqPinNOe <= 1'b0;
      end
      else
      begin
         irqPinNOe <= irqPending && !intOff;
      end
   end

   assign irqPinNOut = 1'b0;

endmodule : jmirq_control

/* File: jmirq_control_monitor.sv */
// port checks of the joystick control block
`timescale 1ns/1ps
module jmirq_control_monitor
#(
   parameter int unsigned MS_CYCLES = 10
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic linkClk,
   input wire logic linkRst,
   input wire logic linkValid,
   input wire logic linkReady,
   input jmirq_pkg::jmirq_req_t linkReq,
   input wire logic linkRspValid,
   input jmirq_pkg::jmirq_rsp_t linkRsp,
   input wire logic measStart,
   input wire logic measDone,
   input jmirq_pkg::jmirq_coord_t measCoord,
   input wire logic irqPinNOut,
   input wire logic irqPinNOe
);
   logic busy;
   logic take;
   logic badWr;
   logic badRd;
   assign take = linkValid && linkReady;
   assign badWr = take && linkReq.kind == jmirq_pkg::JMIRQ_REQ_WRITE
      && (linkReq.addr < 8'h0F || linkReq.addr == 8'h10 || linkReq.addr == 8'h11
      || linkReq.addr > 8'h15);
   assign badRd = take && linkReq.kind == jmirq_pkg::JMIRQ_REQ_READ && linkReq.addr > 8'h15;
   // conversion in flight between start and done
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         busy <= 1'b0;
      else if (measStart)
         busy <= 1'b1;
      else if (measDone)
         busy <= 1'b0;
   end
   drive_low_a:
      assert property (@(posedge clk) disable iff (sys_rst) irqPinNOut == 1'b0)
      else $error("pin level not low");
   irq_cause_a:
      assert property (@(posedge clk) disable iff (sys_rst) $rose(irqPinNOe) |-> $past(measDone, 2))
      else $error("interrupt without measurement");
   start_idle_a:
      assert property (@(posedge clk) disable iff (sys_rst) measStart |-> !busy)
      else $error("start during conversion");
   rsp_pulse_a:
      assert property (@(posedge linkClk) disable iff (linkRst) linkRspValid |=> !linkRspValid)
      else $error("answer longer than one cycle");
   answer_bound_a:
      assert property (@(posedge linkClk) disable iff (linkRst)
         take |=> !linkReady ##[0:12] linkRspValid)
      else $error("answer missing");
   ready_back_a:
      assert property (@(posedge linkClk) disable iff (linkRst) linkRspValid |-> linkReady)
      else $error("not ready at answer");
   write_refused_a:
      assert property (@(posedge linkClk) disable iff (linkRst)
         badWr |=> !linkRspValid until (linkRspValid && !linkRsp.valid))
      else $error("bad write acknowledged");
   read_zero_a:
      assert property (@(posedge linkClk) disable iff (linkRst)
         badRd |=> !linkRspValid until (linkRspValid && linkRsp.data == 8'h00))
      else $error("unmapped read not zero");
   cover property (@(posedge clk) measStart);
   cover property (@(posedge clk) $rose(irqPinNOe));
   cover property (@(posedge clk) $fell(irqPinNOe));
   cover property (@(posedge linkClk) badWr);
endmodule : jmirq_control_monitor

/* File: jmirq_host_model.sv */
// host side of the register link: one request at a time
`timescale 1ns/1ps
module jmirq_host_model
(
   input wire logic linkClk,
   input wire logic linkReady,
   input wire logic linkRspValid,
   input jmirq_pkg::jmirq_rsp_t linkRsp,
   output logic linkValid,
   output jmirq_pkg::jmirq_req_t linkReq
);
   int lag = 0;
   initial
   begin
      linkValid = 1'b0;
      linkReq = '0;
   end
   task automatic xfer(input jmirq_pkg::jmirq_kind_t k, input logic [7:0] a,
      input logic [7:0] d, output jmirq_pkg::jmirq_rsp_t r);
      int n;
      r = 'x;
      n = 0;
      repeat (lag + 1) @(negedge linkClk);
      while (linkReady !== 1'b1 && n < 20)
      begin
         @(negedge linkClk);
         n++;
      end
      linkValid <= 1'b1;
      linkReq <= '{kind: k, addr: a, data: d};
      // taken at the rising edge in between
      @(negedge linkClk);
      linkValid <= 1'b0;
      linkReq <= ~linkReq;
      n = 0;
      while (linkRspValid !== 1'b1 && n < 20)
      begin
         @(negedge linkClk);
         n++;
      end
      if (linkRspValid === 1'b1)
         r = linkRsp;
   endtask : xfer
endmodule : jmirq_host_model

/* File: jmirq_control_tb_top.sv */
// self-checking bench of the joystick control block
`timescale 1ns/1ps
module jmirq_control_tb_top;
   localparam int unsigned MSC = 10;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic sys_rst = 1'b1;
   logic linkRst = 1'b1;
   logic measDone = 1'b0;
   jmirq_pkg::jmirq_coord_t measCoord = '0;
   jmirq_pkg::jmirq_coord_t knob = '0;
   logic linkValid;
   logic linkReady;
   logic linkRspValid;
   logic measStart;
   logic irqPinNOut;
   logic irqPinNOe;
   jmirq_pkg::jmirq_req_t linkReq;
   jmirq_pkg::jmirq_rsp_t linkRsp;
   jmirq_pkg::jmirq_rsp_t rsp;
   int nFail = 0;
   int nCompared = 0;
   int cyc = 0;
   int convLen = 300;
   int convCnt = 0;
   initial forever #4 clk = ~clk;
   initial
   begin
      #13;
      forever #40 linkClk = ~linkClk;
   end
   jmirq_control #(.MS_CYCLES(MSC)) uut (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
      .linkRst(linkRst), .linkValid(linkValid), .linkReady(linkReady), .linkReq(linkReq),
      .linkRspValid(linkRspValid), .linkRsp(linkRsp), .measStart(measStart),
      .measDone(measDone), .measCoord(measCoord), .irqPinNOut(irqPinNOut),
      .irqPinNOe(irqPinNOe));
   jmirq_host_model host (.linkClk(linkClk), .linkReady(linkReady),
      .linkRspValid(linkRspValid), .linkRsp(linkRsp), .linkValid(linkValid),
      .linkReq(linkReq));
   // analog front end: conversion time set by convLen, coordinates valid only with done
   always @(negedge clk)
   begin
      measDone <= !sys_rst && convCnt == 1;
      measCoord <= (convCnt == 1) ? knob : ~measCoord;
      if (sys_rst || convCnt == 1)
         convCnt <= 0;
      else if (convCnt > 1)
         convCnt <= convCnt - 1;
      else if (measStart === 1'b1)
         convCnt <= convLen;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         nFail++;
         endSim();
      end
   end
   task automatic endSim;
      $display("compared %0d, mismatches %0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : endSim
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      nCompared++;
      if (got !== exp)
      begin
         nFail++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : chkByte
   task automatic chkBit(input logic got, input logic exp);
      nCompared++;
      if (got !== exp)
      begin
         nFail++;
         $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chkBit
   task automatic chkCount(input int got, input int exp);
      nCompared++;
      if (got != exp)
      begin
         nFail++;
         $display("wrong value at %0t: period %0d, expected %0d", $time, got, exp);
      end
   endtask : chkCount
   task automatic rst;
      @(negedge linkClk);
      linkRst <= 1'b1;
      sys_rst <= 1'b1;
      repeat (6) @(negedge linkClk);
      linkRst <= 1'b0;
      @(negedge clk);
      sys_rst <= 1'b0;
   endtask : rst
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(jmirq_pkg::JMIRQ_REQ_READ, a, 8'h00, rsp);
      chkBit(rsp.valid, 1'b1);
      chkByte(rsp.data, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ack);
      host.xfer(jmirq_pkg::JMIRQ_REQ_WRITE, a, d, rsp);
      chkBit(rsp.valid, ack);
   endtask : wr
   task automatic req(input jmirq_pkg::jmirq_kind_t k, input logic [7:0] a);
      host.xfer(k, a, 8'h00, rsp);
   endtask : req
   task automatic waitIrq(input logic lvl, input int lim);
      int n;
      n = 0;
      while (irqPinNOe !== lvl && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      chkBit(irqPinNOe, lvl);
   endtask : waitIrq
   task automatic nextStart(output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (measStart !== 1'b1 && n < 5000);
   endtask : nextStart
   initial
   begin
      int tbMs [8] = '{20, 40, 80, 100, 140, 200, 260, 320};
      logic [7:0] rv [7] = '{8'hF0, 8'h00, 8'h00, 8'h05, 8'hFB, 8'h05, 8'hFB};
      logic [7:0] bad [4] = '{8'h10, 8'h11, 8'h0E, 8'h20};
      logic [16:0] zone [6] = '{17'h00000, 17'h005FB, 17'h10600, 17'h1FA00, 17'h10006,
         17'h100FA};
      int n;
      rst();
      for (int i = 0; i < 7; i++)
         rd(8'h0F + 8'(i), rv[i]);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h12 + 8'(i), 8'h80 + 8'(i), 1'b1);
         rd(8'h12 + 8'(i), 8'h80 + 8'(i));
      end
      for (int i = 0; i < 4; i++)
         wr(bad[i], 8'h55, 1'b0);
      host.xfer(jmirq_pkg::JMIRQ_REQ_READ, 8'h20, 8'h00, rsp);
      chkByte(rsp.data, 8'h00);
      knob = 16'h03FE;
      req(jmirq_pkg::JMIRQ_REQ_YACK, 8'h00);
      waitIrq(1'b1, 600);
      req(jmirq_pkg::JMIRQ_REQ_PTR, 8'h12);
      rd(8'h10, 8'h03);
      rd(8'h11, 8'hFE);
      rd(8'h0F, 8'hF1);
      knob = 16'h0701;
      req(jmirq_pkg::JMIRQ_REQ_YACK, 8'h00);
      waitIrq(1'b0, 2);
      waitIrq(1'b1, 600);
      rd(8'h10, 8'h03);
      req(jmirq_pkg::JMIRQ_REQ_PTR, 8'h12);
      rd(8'h10, 8'h07);
      wr(8'h0F, 8'h02, 1'b1);
      waitIrq(1'b0, 20);
      req(jmirq_pkg::JMIRQ_REQ_PTR, 8'h12);
      rd(8'h0F, 8'hF0);
      rd(8'h12, 8'h05);
      convLen = 30;
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h0F, {1'b0, 3'(i), 4'h0}, 1'b1);
         repeat (3) nextStart(n);
         chkCount(n, tbMs[i] * MSC);
      end
      chkBit(irqPinNOe, 1'b1);
      // knob still outside the zone: interrupt pending while the pin is released
      wr(8'h0F, 8'h0C, 1'b1);
      req(jmirq_pkg::JMIRQ_REQ_YACK, 8'h00);
      repeat (2) nextStart(n);
      repeat (convLen + 5) @(negedge clk);
      chkBit(irqPinNOe, 1'b0);
      // clear with the knob centred so that enabling the pin finds nothing pending
      knob = 16'h0000;
      req(jmirq_pkg::JMIRQ_REQ_YACK, 8'h00);
      wr(8'h0F, 8'h04, 1'b1);
      host.lag = 3;
      for (int i = 0; i < 6; i++)
      begin
         knob = zone[i][15:0];
         req(jmirq_pkg::JMIRQ_REQ_YACK, 8'h00);
         repeat (450) @(negedge clk);
         chkBit(irqPinNOe, zone[i][16]);
      end
      host.lag = 0;
      wr(8'h12, 8'h7F, 1'b1);
      rst();
      rd(8'h12, 8'h05);
      rd(8'h0F, 8'hF0);
      endSim();
   end
endmodule : jmirq_control_tb_top
bind jmirq_control jmirq_control_monitor #(.MS_CYCLES(MS_CYCLES)) mon (.clk(clk),
   .sys_rst(sys_rst), .linkClk(linkClk), .linkRst(linkRst), .linkValid(linkValid),
   .linkReady(linkReady), .linkReq(linkReq), .linkRspValid(linkRspValid), .linkRsp(linkRsp),
   .measStart(measStart), .measDone(measDone), .measCoord(measCoord),
   .irqPinNOut(irqPinNOut), .irqPinNOe(irqPinNOe));
